// file: logic/sp2_acct.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Per-frame byte total and class test for rate limiting
module sp2_acct
  import sp2_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  sp2_acct_if.dst acc
);

  logic cnt_r;
  logic cnt_nxt;
  logic [11:0] bytes_r;
  logic [11:0] bytes_nxt;

  // Class filter and byte total, updated on each request
  always_comb
  begin
    cnt_nxt = cnt_r;
    bytes_nxt = bytes_r;
    if (acc.req)
    begin
      cnt_nxt = 1'b1;
      if (acc.ingress)
      begin
        case (sp2_lim_t'(acc.mode))
          SP2_LIM_ALL: cnt_nxt = 1'b1;
          SP2_LIM_BMF: cnt_nxt = acc.bcast | acc.mcast | acc.flood;
          SP2_LIM_BM: cnt_nxt = acc.bcast | acc.mcast;
          SP2_LIM_B: cnt_nxt = acc.bcast;
          default: cnt_nxt = 1'b1;
        endcase
      end
      bytes_nxt = {1'b0, acc.len}
        + (acc.gap ? SP2_GAP_BYTES : 12'h000)
        + (acc.pre ? SP2_PRE_BYTES : 12'h000);
    end
  end

  // Answer registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_r <= 1'b0;
      bytes_r <= 12'h000;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      bytes_r <= bytes_nxt;
    end
  end

  assign acc.cnt = cnt_r;
  assign acc.bytes = bytes_r;

  // Byte total tracks the two count options
  property p_bytes_sum;
    @(posedge clk_sys) disable iff (!rst_n)
    acc.req |=> bytes_r == {1'b0, $past(acc.len)}
      + ($past(acc.gap) ? 12'h00C : 12'h000)
      + ($past(acc.pre) ? 12'h008 : 12'h000);
  endproperty
  a_bytes_sum: assert property (p_bytes_sum)
    else $error("frame byte total wrong");

  // Broadcast-only mode never counts non-broadcast ingress frames
  property p_bcast_only;
    @(posedge clk_sys) disable iff (!rst_n)
    (acc.req && acc.ingress && acc.mode == 2'b11 && !acc.bcast)
      |=> !cnt_r;
  endproperty
  a_bcast_only: assert property (p_bcast_only)
    else $error("non-broadcast frame counted");

endmodule
`default_nettype wire

// file: logic/sp2_acct_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Rate accounting request, settings and answer
interface sp2_acct_if;
  logic req;
  logic ingress;
  logic bcast;
  logic mcast;
  logic flood;
  logic [10:0] len;
  logic [1:0] mode;
  logic gap;
  logic pre;
  logic cnt;
  logic [11:0] bytes;
  modport src (output req, ingress, bcast, mcast, flood, len, mode, gap,
               pre, input cnt, bytes);
  modport dst (input req, ingress, bcast, mcast, flood, len, mode, gap,
               pre, output cnt, bytes);
endinterface
`default_nettype wire

// file: logic/sp2_pkg.sv
`default_nettype none
// ==========================================================
// Port two control register package
package sp2_pkg;

  // ========================================================
  // Register byte offsets on the host interface
  localparam logic [11:0] SP2_OFF_CTRL_B = 12'h086;
  localparam logic [11:0] SP2_OFF_DEF_TAG = 12'h088;
  localparam logic [11:0] SP2_OFF_CTRL_C = 12'h08A;

  // ========================================================
  // Reset values
  localparam logic [15:0] SP2_RST_CTRL_B = 16'h0607;
  localparam logic [15:0] SP2_RST_DEF_TAG = 16'h0001;
  localparam logic [15:0] SP2_RST_CTRL_C = 16'h0002;

  // ========================================================
  // Bits that software may change; the rest hold reset value
  localparam logic [15:0] SP2_WMSK_CTRL_B = 16'h07E8;
  localparam logic [15:0] SP2_WMSK_DEF_TAG = 16'hFFFF;
  localparam logic [15:0] SP2_WMSK_CTRL_C = 16'h000F;

  // ========================================================
  // Field positions in the first control register
  localparam int SP2_B_TX_EN = 10;
  localparam int SP2_B_RX_EN = 9;
  localparam int SP2_B_LRN_DIS = 8;
  localparam int SP2_B_MIR_DST = 7;
  localparam int SP2_B_RX_MON = 6;
  localparam int SP2_B_TX_MON = 5;
  localparam int SP2_B_PRI_CEIL = 3;
  localparam int SP2_B_MEMB_LO = 0;

  // Field positions in the default tag register
  localparam int SP2_T_PRI_LO = 13;
  localparam int SP2_T_CFI = 12;
  localparam int SP2_T_VID_LO = 0;

  // Field positions in the second control register
  localparam int SP2_C_MODE_LO = 2;
  localparam int SP2_C_GAP = 1;
  localparam int SP2_C_PRE = 0;

  // ========================================================
  // Membership bit of each switch port
  localparam int SP2_PORT_ONE = 0;
  localparam int SP2_PORT_TWO = 1;
  localparam int SP2_PORT_HOST = 2;

  // ========================================================
  // Extra bytes per frame for rate accounting
  localparam logic [11:0] SP2_GAP_BYTES = 12'h00C;
  localparam logic [11:0] SP2_PRE_BYTES = 12'h008;

  // Ingress limit classes
  typedef enum logic [1:0] {
    SP2_LIM_ALL,
    SP2_LIM_BMF,
    SP2_LIM_BM,
    SP2_LIM_B
  } sp2_lim_t;

endpackage
`default_nettype wire

// file: logic/sp2_regs.sv
// Overview of operation
// - Transmit enable bit 10 gates all transmission; set after reset.
// - Receive enable bit 9 gates reception; cleared drops frames.
// - Learning disable bit 8 stops source address learning; clear at reset.
// - Bit 7 makes this port the mirror destination for monitored frames.
// - Bit 6 marks every received frame monitored and copies it.
// - Bit 5 marks every transmitted frame monitored and copies it.
// - Ceiling bit 3 clamps frame priority to default-tag user priority.
// - Membership bits: 2 host port, 1 port two, 0 port one.
// - Frames pass only to or from ports whose membership bit is one.
// - Default tag bits 15:13 are user priority, reset zero.
// - Default tag bit 12 is the CFI bit, reset zero.
// - Default tag bits 11:0 are the default VLAN id, reset one.
// - Untagged or null-VID ingress frames take the default VLAN id.
// - Stored default tag is used when tagging untagged egress frames that came in on port two.
// - Ingress limit mode selects counted frame classes.
// - Gap bit adds twelve bytes per frame to rate totals.
// - Preamble bit adds eight bytes per frame to rate totals.
// - Inserted tag is the default tag of the frame's ingress port.
`timescale 1ns/10ps
`default_nettype none
module sp2_regs
  import sp2_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] hst_addr,
  input wire logic hst_wr,
  input wire logic hst_rd,
  input wire logic [1:0] hst_be,
  input wire logic [15:0] hst_wdata,
  output logic [15:0] hst_rdata_r,
  input wire logic in_sof,
  input wire logic in_tagged,
  input wire logic [11:0] in_vid,
  input wire logic [2:0] in_prio,
  input wire logic in_bcast,
  input wire logic in_mcast,
  input wire logic in_flood,
  input wire logic [10:0] in_len,
  output logic in_ok_r,
  output logic [11:0] in_vid_r,
  output logic [2:0] in_prio_r,
  output logic in_learn_r,
  output logic in_mon_r,
  output logic [2:0] in_fwd_r,
  output logic in_cnt_r,
  output logic [11:0] in_bytes_r,
  input wire logic eg_sof,
  input wire logic eg_untag_rx,
  input wire logic eg_ins_en,
  input wire logic [1:0] eg_src_port,
  input wire logic [15:0] eg_src_tag,
  input wire logic [10:0] eg_len,
  output logic eg_ok_r,
  output logic eg_tag_add_r,
  output logic [15:0] eg_tag_r,
  output logic eg_mon_r,
  output logic [11:0] eg_bytes_r,
  output logic mir_dst_r
);

  // ========================================================
  // Helpers
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:1] == o[11:1]);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0] be,
                                        input logic [15:0] wm);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wm;
    merge = (old & ~lane) | (wd & lane);
  endfunction

  // ========================================================
  // Register file
  logic [15:0] ctl_b_r;
  logic [15:0] ctl_b_nxt;
  logic [15:0] tag_r;
  logic [15:0] tag_nxt;
  logic [15:0] ctl_c_r;
  logic [15:0] ctl_c_nxt;
  logic [15:0] rdata_nxt;

  // Writes and registered read data
  always_comb
  begin
    ctl_b_nxt = ctl_b_r;
    tag_nxt = tag_r;
    ctl_c_nxt = ctl_c_r;
    rdata_nxt = hst_rdata_r;
    if (hst_wr)
    begin
      if (hit(hst_addr, SP2_OFF_CTRL_B))
        ctl_b_nxt = merge(ctl_b_r, hst_wdata, hst_be, SP2_WMSK_CTRL_B);
      if (hit(hst_addr, SP2_OFF_DEF_TAG))
        tag_nxt = merge(tag_r, hst_wdata, hst_be, SP2_WMSK_DEF_TAG);
      if (hit(hst_addr, SP2_OFF_CTRL_C))
        ctl_c_nxt = merge(ctl_c_r, hst_wdata, hst_be, SP2_WMSK_CTRL_C);
    end
    if (hst_rd)
    begin
      if (hit(hst_addr, SP2_OFF_CTRL_B))
        rdata_nxt = ctl_b_r;
      else if (hit(hst_addr, SP2_OFF_DEF_TAG))
        rdata_nxt = tag_r;
      else if (hit(hst_addr, SP2_OFF_CTRL_C))
        rdata_nxt = ctl_c_r;
      else
        rdata_nxt = 16'h0000;
    end
  end

  // Register file and read data flip-flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctl_b_r <= SP2_RST_CTRL_B;
      tag_r <= SP2_RST_DEF_TAG;
      ctl_c_r <= SP2_RST_CTRL_C;
      hst_rdata_r <= 16'h0000;
    end
    else
    begin
      ctl_b_r <= ctl_b_nxt;
      tag_r <= tag_nxt;
      ctl_c_r <= ctl_c_nxt;
      hst_rdata_r <= rdata_nxt;
    end
  end

  // ========================================================
  // Field views
  logic tx_en;
  logic rx_en;
  logic lrn_dis;
  logic rx_mon;
  logic tx_mon;
  logic pri_ceil;
  logic [2:0] memb;
  logic [2:0] def_pri;
  logic [11:0] def_vid;

  assign tx_en = ctl_b_r[SP2_B_TX_EN];
  assign rx_en = ctl_b_r[SP2_B_RX_EN];
  assign lrn_dis = ctl_b_r[SP2_B_LRN_DIS];
  assign rx_mon = ctl_b_r[SP2_B_RX_MON];
  assign tx_mon = ctl_b_r[SP2_B_TX_MON];
  assign pri_ceil = ctl_b_r[SP2_B_PRI_CEIL];
  assign memb = ctl_b_r[SP2_B_MEMB_LO +: 3];
  assign def_pri = tag_r[SP2_T_PRI_LO +: 3];
  assign def_vid = tag_r[SP2_T_VID_LO +: 12];

  // ========================================================
  // Ingress decisions, taken from settings at frame start
  logic in_ok_nxt;
  logic [11:0] in_vid_nxt;
  logic [2:0] in_prio_nxt;
  logic in_learn_nxt;
  logic in_mon_nxt;
  logic [2:0] in_fwd_nxt;

  // Next ingress decisions on a frame start
  always_comb
  begin
    in_ok_nxt = in_ok_r;
    in_vid_nxt = in_vid_r;
    in_prio_nxt = in_prio_r;
    in_learn_nxt = in_learn_r;
    in_mon_nxt = in_mon_r;
    in_fwd_nxt = in_fwd_r;
    if (in_sof)
    begin
      in_ok_nxt = rx_en;
      in_vid_nxt = (!in_tagged || in_vid == 12'h000) ? def_vid : in_vid;
      in_prio_nxt = (pri_ceil && in_prio > def_pri) ? def_pri : in_prio;
      in_learn_nxt = rx_en & ~lrn_dis;
      in_mon_nxt = rx_en & rx_mon;
      in_fwd_nxt = rx_en ? memb : 3'h0;
    end
  end

  // Ingress decision flip-flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      in_ok_r <= 1'b0;
      in_vid_r <= 12'h000;
      in_prio_r <= 3'h0;
      in_learn_r <= 1'b0;
      in_mon_r <= 1'b0;
      in_fwd_r <= 3'h0;
    end
    else
    begin
      in_ok_r <= in_ok_nxt;
      in_vid_r <= in_vid_nxt;
      in_prio_r <= in_prio_nxt;
      in_learn_r <= in_learn_nxt;
      in_mon_r <= in_mon_nxt;
      in_fwd_r <= in_fwd_nxt;
    end
  end

  // ========================================================
  // Egress decisions
  logic eg_ok_nxt;
  logic eg_tag_add_nxt;
  logic [15:0] eg_tag_nxt;
  logic eg_mon_nxt;
  logic mir_dst_nxt;
  logic src_member;

  assign src_member = memb[eg_src_port];

  // Next egress decisions on a frame start; mirror destination bit every cycle
  always_comb
  begin
    eg_ok_nxt = eg_ok_r;
    eg_tag_add_nxt = eg_tag_add_r;
    eg_tag_nxt = eg_tag_r;
    eg_mon_nxt = eg_mon_r;
    mir_dst_nxt = ctl_b_r[SP2_B_MIR_DST];
    if (eg_sof)
    begin
      eg_ok_nxt = tx_en & src_member;
      eg_tag_add_nxt = tx_en & src_member & eg_ins_en & eg_untag_rx;
      // Own default tag for local ingress, else the source port's
      eg_tag_nxt = (eg_src_port == 2'(SP2_PORT_TWO)) ? tag_r
                                                      : eg_src_tag;
      eg_mon_nxt = tx_en & src_member & tx_mon;
    end
  end

  // Egress decision flip-flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      eg_ok_r <= 1'b0;
      eg_tag_add_r <= 1'b0;
      eg_tag_r <= 16'h0000;
      eg_mon_r <= 1'b0;
      mir_dst_r <= 1'b0;
    end
    else
    begin
      eg_ok_r <= eg_ok_nxt;
      eg_tag_add_r <= eg_tag_add_nxt;
      eg_tag_r <= eg_tag_nxt;
      eg_mon_r <= eg_mon_nxt;
      mir_dst_r <= mir_dst_nxt;
    end
  end

  // ========================================================
  // Rate accounting for both directions
  sp2_acct_if acc_in ();
  sp2_acct_if acc_eg ();

  assign acc_in.req = in_sof;
  assign acc_in.ingress = 1'b1;
  assign acc_in.bcast = in_bcast;
  assign acc_in.mcast = in_mcast;
  assign acc_in.flood = in_flood;
  assign acc_in.len = in_len;
  assign acc_in.mode = ctl_c_r[SP2_C_MODE_LO +: 2];
  assign acc_in.gap = ctl_c_r[SP2_C_GAP];
  assign acc_in.pre = ctl_c_r[SP2_C_PRE];
  assign acc_eg.req = eg_sof;
  assign acc_eg.ingress = 1'b0;
  assign acc_eg.bcast = 1'b0;
  assign acc_eg.mcast = 1'b0;
  assign acc_eg.flood = 1'b0;
  assign acc_eg.len = eg_len;
  assign acc_eg.mode = ctl_c_r[SP2_C_MODE_LO +: 2];
  assign acc_eg.gap = ctl_c_r[SP2_C_GAP];
  assign acc_eg.pre = ctl_c_r[SP2_C_PRE];
  assign in_cnt_r = acc_in.cnt;
  assign in_bytes_r = acc_in.bytes;
  assign eg_bytes_r = acc_eg.bytes;

  sp2_acct u_acct_in (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .acc(acc_in)
  );

  sp2_acct u_acct_eg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .acc(acc_eg)
  );

  // ========================================================
  // Checks
  sequence s_in_frame;
    in_sof ##0 rx_en;
  endsequence

  property p_rx_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (in_sof && !rx_en) |=> !in_ok_r && !in_mon_r && in_fwd_r == 3'h0;
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("frame accepted while reception off");

  property p_tx_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (eg_sof && !tx_en) |=> !eg_ok_r && !eg_tag_add_r;
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("frame sent while transmission off");

  property p_learn;
    @(posedge clk_sys) disable iff (!rst_n)
    s_in_frame |=> in_learn_r == !$past(lrn_dis);
  endproperty
  a_learn: assert property (p_learn)
    else $error("learning does not follow disable bit");

  property p_def_vid;
    @(posedge clk_sys) disable iff (!rst_n)
    (in_sof && !in_tagged) |=> in_vid_r == $past(def_vid);
  endproperty
  a_def_vid: assert property (p_def_vid)
    else $error("untagged frame missed default id");

  property p_ceiling;
    @(posedge clk_sys) disable iff (!rst_n)
    in_sof |=> in_prio_r <= ($past(pri_ceil) ? $past(def_pri) : 3'h7)
      && ($past(pri_ceil) || in_prio_r == $past(in_prio));
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("priority ceiling wrong");

  property p_rx_mirror;
    @(posedge clk_sys) disable iff (!rst_n)
    s_in_frame |=> in_mon_r == $past(rx_mon);
  endproperty
  a_rx_mirror: assert property (p_rx_mirror)
    else $error("receive monitoring wrong");

  property p_ins_tag;
    @(posedge clk_sys) disable iff (!rst_n)
    (eg_sof && eg_src_port == 2'h1) |=> eg_tag_r == $past(tag_r);
  endproperty
  a_ins_tag: assert property (p_ins_tag)
    else $error("inserted tag not own default tag");

  property p_tag_reset;
    @(posedge clk_sys)
    !rst_n |=> tag_r == 16'h0001 && ctl_b_r[10:9] == 2'b11;
  endproperty
  a_tag_reset: assert property (p_tag_reset)
    else $error("reset values wrong");

  property p_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
    ctl_c_r[15:4] == 12'h000 && !ctl_b_r[15] && !ctl_b_r[4];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit changed");

  // Egress frames are always counted by the accounting unit
  property p_eg_counted;
    @(posedge clk_sys) disable iff (!rst_n)
    eg_sof |=> acc_eg.cnt;
  endproperty
  a_eg_counted: assert property (p_eg_counted)
    else $error("egress frame not counted");

endmodule
`default_nettype wire

// file: test/sp2_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the port two control registers
module sp2_regs_bench import sp2_pkg::*;;
  logic clk_sys, rst_n;
  logic [11:0] hst_addr;
  logic hst_wr, hst_rd;
  logic [1:0] hst_be;
  logic [15:0] hst_wdata, hst_rdata_r;
  logic in_sof, in_tagged, in_bcast, in_mcast, in_flood;
  logic [11:0] in_vid;
  logic [2:0] in_prio;
  logic [10:0] in_len, eg_len;
  logic in_ok_r, in_learn_r, in_mon_r, in_cnt_r;
  logic [11:0] in_vid_r, in_bytes_r, eg_bytes_r;
  logic [2:0] in_prio_r, in_fwd_r;
  logic eg_sof, eg_untag_rx, eg_ins_en;
  logic [1:0] eg_src_port;
  logic [15:0] eg_src_tag, eg_tag_r;
  logic eg_ok_r, eg_tag_add_r, eg_mon_r, mir_dst_r;
  // Model copies of the three registers
  logic [15:0] m_cb, m_tg, m_cc;
  int n_errors = 0;
  int n_tests = 0;
  int n_cyc = 0;

  // ========================================================
  // Design under test
  sp2_regs uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hst_addr(hst_addr),
    .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_be(hst_be),
    .hst_wdata(hst_wdata), .hst_rdata_r(hst_rdata_r),
    .in_sof(in_sof), .in_tagged(in_tagged), .in_vid(in_vid),
    .in_prio(in_prio), .in_bcast(in_bcast), .in_mcast(in_mcast),
    .in_flood(in_flood), .in_len(in_len), .in_ok_r(in_ok_r),
    .in_vid_r(in_vid_r), .in_prio_r(in_prio_r),
    .in_learn_r(in_learn_r), .in_mon_r(in_mon_r),
    .in_fwd_r(in_fwd_r), .in_cnt_r(in_cnt_r),
    .in_bytes_r(in_bytes_r), .eg_sof(eg_sof),
    .eg_untag_rx(eg_untag_rx), .eg_ins_en(eg_ins_en),
    .eg_src_port(eg_src_port), .eg_src_tag(eg_src_tag),
    .eg_len(eg_len), .eg_ok_r(eg_ok_r), .eg_tag_add_r(eg_tag_add_r),
    .eg_tag_r(eg_tag_r), .eg_mon_r(eg_mon_r),
    .eg_bytes_r(eg_bytes_r), .mir_dst_r(mir_dst_r)
  );

  // Clock of 100 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard well above the expected run length
  always @(posedge clk_sys)
  begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 8000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ========================================================
  // Shared tasks
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] upd(input logic [15:0] r, d, m);
    return (r & ~m) | (d & m);
  endfunction

  // Register write; the model follows after the taking edge
  task automatic wr(input logic [11:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}};
    @(posedge clk_sys);
    hst_addr <= a;
    hst_be <= be;
    hst_wdata <= d;
    hst_wr <= 1'b1;
    @(posedge clk_sys);
    hst_wr <= 1'b0;
    if (a[11:1] == SP2_OFF_CTRL_B[11:1])
      m_cb = upd(m_cb, d, bm & 16'h07E8);
    if (a[11:1] == SP2_OFF_DEF_TAG[11:1])
      m_tg = upd(m_tg, d, bm);
    if (a[11:1] == SP2_OFF_CTRL_C[11:1])
      m_cc = upd(m_cc, d, bm & 16'h000F);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    hst_addr <= a;
    hst_rd <= 1'b1;
    @(posedge clk_sys);
    hst_rd <= 1'b0;
    @(negedge clk_sys);
    chk(hst_rdata_r, exp);
  endtask

  task automatic rd_all();
    rd(SP2_OFF_CTRL_B, m_cb);
    rd(SP2_OFF_DEF_TAG, m_tg);
    rd(SP2_OFF_CTRL_C, m_cc);
    rd(12'h08E, 16'h0000);
  endtask

  // One ingress and one egress descriptor, checked against the model
  task automatic frame();
    logic [11:0] x, ev;
    logic [2:0] dp, ep;
    logic c, ok;
    @(posedge clk_sys);
    in_sof <= 1'b1;
    eg_sof <= 1'b1;
    in_tagged <= 1'($urandom);
    in_vid <= ($urandom_range(0, 3) == 0) ? 12'h000 : 12'($urandom);
    in_prio <= 3'($urandom);
    in_bcast <= 1'($urandom);
    in_mcast <= 1'($urandom);
    in_flood <= 1'($urandom);
    in_len <= 11'($urandom);
    eg_untag_rx <= 1'($urandom);
    eg_ins_en <= 1'($urandom);
    eg_src_port <= 2'($urandom_range(0, 2));
    eg_src_tag <= 16'($urandom);
    eg_len <= 11'($urandom);
    @(posedge clk_sys);
    in_sof <= 1'b0;
    eg_sof <= 1'b0;
    @(negedge clk_sys);
    x = (m_cc[1] ? 12'h00C : 12'h000) + (m_cc[0] ? 12'h008 : 12'h000);
    ev = (!in_tagged || in_vid == 12'h000) ? m_tg[11:0] : in_vid;
    dp = m_tg[15:13];
    ep = (m_cb[3] && in_prio > dp) ? dp : in_prio;
    case (m_cc[3:2])
      2'h0: c = 1'b1;
      2'h1: c = in_bcast | in_mcast | in_flood;
      2'h2: c = in_bcast | in_mcast;
      default: c = in_bcast;
    endcase
    chk(16'(in_ok_r), 16'(m_cb[9]));
    if (m_cb[9])
    begin
      chk(16'(in_vid_r), 16'(ev));
      chk(16'(in_prio_r), 16'(ep));
      chk(16'(in_learn_r), 16'(!m_cb[8]));
      chk(16'(in_mon_r), 16'(m_cb[6]));
      chk(16'(in_fwd_r), 16'(m_cb[2:0]));
      chk(16'(in_cnt_r), 16'(c));
      chk(16'(in_bytes_r), 16'(12'(in_len) + x));
    end
    else
      chk(16'({in_learn_r, in_mon_r, in_fwd_r}), 16'h0000);
    ok = m_cb[10] & m_cb[eg_src_port];
    chk(16'(eg_ok_r), 16'(ok));
    if (ok)
    begin
      chk(16'(eg_tag_add_r), 16'(eg_ins_en & eg_untag_rx));
      if (eg_ins_en && eg_untag_rx)
        chk(eg_tag_r, (eg_src_port == 2'h1) ? m_tg : eg_src_tag);
      chk(16'(eg_mon_r), 16'(m_cb[5]));
      chk(16'(eg_bytes_r), 16'(12'(eg_len) + x));
    end
    else
      chk(16'({eg_tag_add_r, eg_mon_r}), 16'h0000);
    chk(16'(mir_dst_r), 16'(m_cb[7]));
  endtask

  task automatic model_reset();
    m_cb = 16'h0607;
    m_tg = 16'h0001;
    m_cc = 16'h0002;
  endtask

  // ========================================================
  // Main sequence
  initial
  begin
    logic [11:0] a;
    rst_n = 1'b0;
    {hst_addr, hst_wr, hst_rd, hst_be, hst_wdata} = '0;
    {in_sof, in_tagged, in_vid, in_prio, in_bcast, in_mcast} = '0;
    {in_flood, in_len, eg_sof, eg_untag_rx, eg_ins_en} = '0;
    {eg_src_port, eg_src_tag, eg_len} = '0;
    model_reset();
    void'($urandom(32'h3efe));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_all();
    repeat (4) frame();
    // Every limit mode, with the gap and preamble options varied
    for (int m = 0; m < 4; m++)
    begin
      wr(SP2_OFF_CTRL_C, 2'b11, 16'(m * 5));
      repeat (6) frame();
    end
    // Random traffic to mapped, reserved and unmapped places
    for (int i = 0; i < 60; i++)
    begin
      case ($urandom_range(0, 4))
        0: a = SP2_OFF_CTRL_B;
        1: a = SP2_OFF_DEF_TAG;
        2: a = SP2_OFF_CTRL_C;
        3: a = 12'h08C;
        default: a = SP2_OFF_CTRL_B + 12'h001;
      endcase
      wr(a, 2'($urandom), 16'($urandom));
      rd_all();
      repeat (3) frame();
    end
    // Reset again in mid-run
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    model_reset();
    rd_all();
    repeat (4) frame();
    end_of_test();
  end
endmodule
`default_nettype wire
